//--- core/egress_consts.svh
/*
  Offsets, field positions, reset values and bus codes of the egress queue weight block.
  Assumes inclusion by bare name from the files of this block only.
*/
`ifndef EGRESS_CONSTS_SVH
`define EGRESS_CONSTS_SVH

// Register indices; byte address is four times the index
`define EQW_IDX_P2Q3 10'h0B3
`define EQW_IDX_P2Q2 10'h0B4
`define EQW_IDX_P2Q1 10'h0B5
`define EQW_IDX_P2Q0 10'h0B6
`define EQW_IDX_P3Q3 10'h0B7
`define EQW_IDX_P3Q2 10'h0B8
`define EQW_IDX_P3Q1 10'h0B9
`define EQW_IDX_P3Q0 10'h0BA
`define EQW_IDX_CTRL 10'h0F0
`define EQW_IDX_STAT 10'h0F1

// Field layout of an egress_queue_weight register
`define EQW_MODE_BIT 7
`define EQW_MODE_RESET 1'b1
`define EQW_RSV_QUEUE_THREE 7'h08
`define EQW_RSV_Q2 7'h04
`define EQW_RSV_Q1 7'h02
`define EQW_RSV_QUEUE_ZERO 7'h01

// Control register fields
`define EQW_CTRL_GLOBAL_BIT 0
`define EQW_CTRL_P2_TWO_BIT 1
`define EQW_CTRL_P3_TWO_BIT 2
`define EQW_CTRL_RESET 3'h0

// AXI response codes
`define EQW_RESP_OKAY 2'h0
`define EQW_RESP_SLVERR 2'h2

`endif

//--- core/egress_pkg.sv
/*
  Types shared by the egress queue weight block.
  Assumes nothing of its surroundings.
*/
package egress_pkg;
  typedef enum logic [1:0] {
    MODE_STRICT = 2'b00,
    MODE_WEIGHT4 = 2'b01,
    MODE_WEIGHT2 = 2'b10
  } sched_mode_t;
endpackage

//--- core/sched_cfg_if.sv
/*
  Carrier between the configuration top and one port scheduler.
  Assumes one clock shared by both sides.
*/
`timescale 1ns/1ps
interface sched_cfg_if;
  egress_pkg::sched_mode_t mode;
  logic slot;
  logic [3:0] req;
  logic [3:0] grant;
  logic grant_valid;
  modport sched (input mode, input slot, input req, output grant, output grant_valid);
  modport cfg (output mode, output slot, output req, input grant, input grant_valid);
endinterface

//--- core/port_mode_resolve.sv
/*
  Resolves the four mode bits of one port into a scheduler mode.
  Assumes mode bits and control bits come from registers on the same clock.
*/
`timescale 1ns/1ps
module port_mode_resolve (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] mode_bits,
  input wire logic global_weight,
  input wire logic two_queue,
  output egress_pkg::sched_mode_t mode
);
  wire logic all_set = &mode_bits;
  wire logic all_clear = ~|mode_bits;
  wire logic weighted = all_set || (all_clear && global_weight);
  egress_pkg::sched_mode_t weight_mode;
  assign weight_mode = two_queue ? egress_pkg::MODE_WEIGHT2 : egress_pkg::MODE_WEIGHT4;
  // Mixed bits are a software fault; strict keeps service deterministic
  assign mode = weighted ? weight_mode : egress_pkg::MODE_STRICT;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_mixed_strict: assert property (
    mode_bits != 4'hF && mode_bits != 4'h0 |-> mode == egress_pkg::MODE_STRICT)
    else $error("mixed mode bits did not give strict service");
endmodule // port_mode_resolve

//--- core/egress_sched.sv
/*
  Egress scheduler of one port: strict or weighted choice among four queues.
  Assumes queue requests and slot pulses come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "egress_consts.svh"
module egress_sched (
  input wire logic clk,
  input wire logic rst,
  sched_cfg_if.sched cfg
);
  localparam logic [15:0] WEIGHTS = {4'(`EQW_RSV_QUEUE_THREE), 4'(`EQW_RSV_Q2), 4'(`EQW_RSV_Q1), 4'(`EQW_RSV_QUEUE_ZERO)};

  function automatic logic [3:0] pick_high(input logic [3:0] v);
    pick_high = v[3] ? 4'h8 : v[2] ? 4'h4 : v[1] ? 4'h2 : v[0] ? 4'h1 : 4'h0;
  endfunction

  logic [3:0] credit [4];
  logic [3:0] has_credit;
  logic [3:0] used3;
  wire logic weighted = cfg.mode != egress_pkg::MODE_STRICT;
  // Two-queue service uses the two lowest queues, weights 2 and 1
  wire logic [3:0] mask = (cfg.mode == egress_pkg::MODE_WEIGHT2) ? 4'h3 : 4'hF;
  wire logic [3:0] live = cfg.req & mask;
  wire logic [3:0] eligible = live & has_credit;
  wire logic reload = weighted && live != 4'h0 && eligible == 4'h0;
  wire logic [3:0] pick = !weighted ? pick_high(cfg.req) : reload ? pick_high(live) : pick_high(eligible);
  wire logic take = cfg.slot && pick != 4'h0;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      has_credit[i] = credit[i] != 4'h0;
    end
  end

  // Credits refill only when every live queue has spent its share
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (rst || !weighted) begin
        credit[i] <= WEIGHTS[i*4 +: 4];
      end else if (take) begin
        credit[i] <= (reload ? WEIGHTS[i*4 +: 4] : credit[i]) - {3'h0, pick[i]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg.grant <= 4'h0;
      cfg.grant_valid <= 1'b0;
    end else begin
      cfg.grant_valid <= take;
      if (take) begin
        cfg.grant <= pick;
      end
    end
  end

  // Helper: top queue grants since the last refill
  always_ff @(posedge clk) begin
    if (rst || !weighted || (take && reload)) begin
      used3 <= (take && reload && pick[3]) ? 4'h1 : 4'h0;
    end else if (take && pick[3]) begin
      used3 <= used3 + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_strict_highest: assert property (
    cfg.mode == egress_pkg::MODE_STRICT && cfg.slot && cfg.req != 4'h0
    |=> cfg.grant_valid && $onehot(cfg.grant) && ($past(cfg.req) & cfg.grant) != 4'h0
      && ($past(cfg.req) & ~4'((cfg.grant << 1) - 4'h1)) == 4'h0)
    else $error("strict service did not grant the highest queue");
  chk_top_share: assert property (
    take && !reload && cfg.mode == egress_pkg::MODE_WEIGHT4 && pick[3] |-> used3 < 4'h8)
    else $error("top queue served beyond its share of eight");
  chk_two_queue_only: assert property (
    cfg.grant_valid && $past(cfg.mode) == egress_pkg::MODE_WEIGHT2 |-> cfg.grant[3:2] == 2'b00)
    else $error("two-queue service granted an upper queue");
  cov_strict_grant: cover property (cfg.mode == egress_pkg::MODE_STRICT && take);
  cov_weight_refill: cover property (cfg.mode == egress_pkg::MODE_WEIGHT4 && take && reload && cfg.req == 4'hF);
  cov_two_queue_low: cover property (cfg.mode == egress_pkg::MODE_WEIGHT2 && take && pick[0]);
endmodule // egress_sched

//--- core/egress_queue_split_cfg.sv
/*
  Egress queue weight registers of ports 2 and 3 with their two schedulers, behind AXI4-Lite.
  Assumes one clock, a synchronous active-high reset, and queue requests and
  transmit slot pulses from switch logic on the same clock.
*/
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "egress_consts.svh"
module egress_queue_split_cfg #(
  parameter int ADDR_W = 12
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [3:0] P2_QUEUE_REQ,
  input wire logic P2_TX_SLOT,
  output logic [3:0] P2_GRANT,
  output logic P2_GRANT_VALID,
  input wire logic [3:0] P3_QUEUE_REQ,
  input wire logic P3_TX_SLOT,
  output logic [3:0] P3_GRANT,
  output logic P3_GRANT_VALID
);
  // Word index of a byte address; misaligned addresses never hit
  function automatic logic [9:0] word_of(input logic [ADDR_W-1:0] a);
    word_of = 10'(a >> 2);
  endfunction

  function automatic logic split_hit(input logic [ADDR_W-1:0] a);
    split_hit = a[1:0] == 2'b00 && word_of(a) >= `EQW_IDX_P2Q3 && word_of(a) <= `EQW_IDX_P3Q0;
  endfunction

  function automatic logic [2:0] split_slot(input logic [ADDR_W-1:0] a);
    split_slot = 3'(word_of(a) - `EQW_IDX_P2Q3);
  endfunction

  // Fixed weight field by queue; slot 0 is the top queue of port 2
  function automatic logic [6:0] rsv_of(input logic [2:0] k);
    case (k[1:0])
      2'd0: rsv_of = `EQW_RSV_QUEUE_THREE;
      2'd1: rsv_of = `EQW_RSV_Q2;
      2'd2: rsv_of = `EQW_RSV_Q1;
      default: rsv_of = `EQW_RSV_QUEUE_ZERO;
    endcase
  endfunction

  // Bit k holds the mode bit of slot k (p2q3..p2q0, p3q3..p3q0)
  logic [7:0] split_mode;
  logic [2:0] ctrl;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;

  sched_cfg_if p2_if ();
  sched_cfg_if p3_if ();

  // Write path: address and data accepted in either order
  // Ready falls while a word is held, so a second address waits for the response
  assign S_AXI_AWREADY = !aw_held;
  assign S_AXI_WREADY = !w_held;
  wire logic aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire logic w_take = S_AXI_WVALID && S_AXI_WREADY;
  wire logic do_write = aw_held && w_held && !S_AXI_BVALID;
  wire logic wr_split = split_hit(aw_addr);
  wire logic [2:0] wr_slot = split_slot(aw_addr);
  wire logic wr_ctrl = aw_addr[1:0] == 2'b00 && word_of(aw_addr) == `EQW_IDX_CTRL;
  wire logic wr_stat = aw_addr[1:0] == 2'b00 && word_of(aw_addr) == `EQW_IDX_STAT;
  wire logic wr_known = wr_split || wr_ctrl || wr_stat;

  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_byte <= S_AXI_WDATA[7:0];
      w_lane0 <= S_AXI_WSTRB[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Only the mode bit is stored; writes to the weight field are dropped
  always_ff @(posedge CLK) begin
    if (RST) begin
      split_mode <= {8{`EQW_MODE_RESET}};
      ctrl <= `EQW_CTRL_RESET;
    end else if (do_write && w_lane0) begin
      if (wr_split) begin
        split_mode[wr_slot] <= w_byte[`EQW_MODE_BIT];
      end
      if (wr_ctrl) begin
        ctrl <= w_byte[2:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `EQW_RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_known ? `EQW_RESP_OKAY : `EQW_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Read path: one outstanding read, data registered
  // A new address waits until the data is taken; this trades throughput for a small decoder
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  wire logic ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire logic rd_split = split_hit(S_AXI_ARADDR);
  wire logic [2:0] rd_slot = split_slot(S_AXI_ARADDR);
  wire logic rd_ctrl = S_AXI_ARADDR[1:0] == 2'b00 && word_of(S_AXI_ARADDR) == `EQW_IDX_CTRL;
  wire logic rd_stat = S_AXI_ARADDR[1:0] == 2'b00 && word_of(S_AXI_ARADDR) == `EQW_IDX_STAT;
  wire logic [6:0] rsv_sel = rsv_of(rd_slot);
  wire logic [31:0] split_word = {24'h00_0000, split_mode[rd_slot], rsv_sel};
  wire logic [31:0] ctrl_word = {29'h0, ctrl};
  wire logic [31:0] stat_word = {20'h0_0000, p3_if.grant, p2_if.grant, 2'(p3_if.mode), 2'(p2_if.mode)};
  wire logic [31:0] rd_word = rd_split ? split_word :
    rd_ctrl ? ctrl_word :
    rd_stat ? stat_word :
    32'h0000_0000;
  wire logic rd_known = rd_split || rd_ctrl || rd_stat;

  always_ff @(posedge CLK) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `EQW_RESP_OKAY;
    end else if (ar_take) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_word;
      S_AXI_RRESP <= rd_known ? `EQW_RESP_OKAY : `EQW_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Port schedulers
  port_mode_resolve p2_mode (
    .clk(CLK),
    .rst(RST),
    .mode_bits(split_mode[3:0]),
    .global_weight(ctrl[`EQW_CTRL_GLOBAL_BIT]),
    .two_queue(ctrl[`EQW_CTRL_P2_TWO_BIT]),
    .mode(p2_if.mode)
  );

  port_mode_resolve p3_mode (
    .clk(CLK),
    .rst(RST),
    .mode_bits(split_mode[7:4]),
    .global_weight(ctrl[`EQW_CTRL_GLOBAL_BIT]),
    .two_queue(ctrl[`EQW_CTRL_P3_TWO_BIT]),
    .mode(p3_if.mode)
  );

  assign p2_if.slot = P2_TX_SLOT;
  assign p2_if.req = P2_QUEUE_REQ;
  assign p3_if.slot = P3_TX_SLOT;
  assign p3_if.req = P3_QUEUE_REQ;

  egress_sched p2_sched (
    .clk(CLK),
    .rst(RST),
    .cfg(p2_if)
  );

  egress_sched p3_sched (
    .clk(CLK),
    .rst(RST),
    .cfg(p3_if)
  );

  assign P2_GRANT = p2_if.grant;
  assign P2_GRANT_VALID = p2_if.grant_valid;
  assign P3_GRANT = p3_if.grant;
  assign P3_GRANT_VALID = p3_if.grant_valid;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  chk_rsv_readback: assert property (ar_take && rd_split |=> S_AXI_RDATA[6:0] == $past(rsv_sel))
    else $error("weight field did not read back its fixed value");
  chk_q0_reset: assert property ($past(RST) |-> split_mode[7] && split_mode[3] && !S_AXI_BVALID)
    else $error("mode bit not set after reset");
  chk_write_resp: assert property (
    do_write && wr_split && w_lane0 |=> S_AXI_BVALID && split_mode[$past(wr_slot)] == $past(w_byte[7]))
    else $error("mode bit write or response missing");
  chk_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped before it was taken");

  // Handshake holding and answer timing
  chk_aw_hold: assert property (
    aw_held && !do_write |=> aw_held && $stable(aw_addr))
    else $error("held write address changed before its response");
  chk_w_hold: assert property (
    w_held && !do_write |=> w_held && $stable(w_byte) && $stable(w_lane0))
    else $error("held write data changed before its response");
  chk_bvalid_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped before it was taken");
  chk_write_answer: assert property (
    aw_held && w_held && !S_AXI_BVALID |=> S_AXI_BVALID)
    else $error("write response late");
  chk_read_answer: assert property (
    S_AXI_ARVALID && !S_AXI_RVALID |=> S_AXI_RVALID)
    else $error("read data late");
  chk_reset_idle: assert property (
    $past(RST) |-> !S_AXI_RVALID && S_AXI_ARREADY && !P2_GRANT_VALID && !P3_GRANT_VALID)
    else $error("bus or grants busy right after reset");

  // Refused, unmapped and ignored accesses
  chk_misaligned_read: assert property (
    S_AXI_ARVALID && !S_AXI_RVALID && S_AXI_ARADDR[1:0] != 2'b00
    |=> S_AXI_RRESP == `EQW_RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000)
    else $error("misaligned read not refused");
  chk_unmapped_read: assert property (
    ar_take && !rd_known |=> S_AXI_RRESP == `EQW_RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_misaligned_write: assert property (
    do_write && aw_addr[1:0] != 2'b00
    |=> S_AXI_BRESP == `EQW_RESP_SLVERR && $stable(split_mode) && $stable(ctrl))
    else $error("misaligned write not refused or stored");
  chk_stat_readonly: assert property (
    do_write && wr_stat |=> $stable(split_mode) && $stable(ctrl))
    else $error("status write changed a register");

  // Register contents
  chk_upper_zero: assert property (
    S_AXI_RVALID |-> S_AXI_RDATA[31:12] == 20'h0_0000)
    else $error("upper read data bits not zero");
  chk_ctrl_write: assert property (
    do_write && wr_ctrl && w_lane0 |=> ctrl == $past(w_byte[2:0]))
    else $error("control write lost");

  // Mode resolution and grants
  chk_p2_strict: assert property (
    split_mode[3:0] == 4'h0 && !ctrl[`EQW_CTRL_GLOBAL_BIT] |-> p2_if.mode == egress_pkg::MODE_STRICT)
    else $error("port 2 not strict with all mode bits clear");
  chk_p2_global: assert property (
    split_mode[3:0] == 4'h0 && ctrl[`EQW_CTRL_GLOBAL_BIT] && !ctrl[`EQW_CTRL_P2_TWO_BIT]
    |-> p2_if.mode == egress_pkg::MODE_WEIGHT4)
    else $error("port 2 not weighted with the global bit set");
  chk_p2_weighted: assert property (
    split_mode[3:0] == 4'hF && !ctrl[`EQW_CTRL_P2_TWO_BIT] |-> p2_if.mode == egress_pkg::MODE_WEIGHT4)
    else $error("port 2 not weighted four-queue");
  chk_p3_weighted: assert property (
    split_mode[7:4] == 4'hF && !ctrl[`EQW_CTRL_P3_TWO_BIT] |-> p3_if.mode == egress_pkg::MODE_WEIGHT4)
    else $error("port 3 not weighted four-queue");
  chk_p3_two_queue: assert property (
    split_mode[7:4] == 4'hF && ctrl[`EQW_CTRL_P3_TWO_BIT] |-> p3_if.mode == egress_pkg::MODE_WEIGHT2)
    else $error("port 3 not weighted two-queue");
  chk_p2_onehot: assert property (
    P2_GRANT_VALID |-> $onehot(P2_GRANT))
    else $error("port 2 grant not one-hot");
  chk_p3_onehot: assert property (
    P3_GRANT_VALID |-> $onehot(P3_GRANT))
    else $error("port 3 grant not one-hot");

  cov_slverr_read: cover property (ar_take && !rd_known);
  cov_both_weighted: cover property (p2_if.mode == egress_pkg::MODE_WEIGHT4 && p3_if.mode == egress_pkg::MODE_WEIGHT2);
endmodule // egress_queue_split_cfg

//--- verification/testbench.sv
/*
  Self-checking bench for the egress queue weight block: register access over AXI4-Lite, scheduler grants.
  Assumes the design's own assertions run inside it; the bench drives every port itself.
*/
`timescale 1ns/1ps
`include "egress_consts.svh"
module testbench;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [11:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic [31:0] S_AXI_WDATA = '0;
  logic [3:0] S_AXI_WSTRB = 4'h0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic [3:0] P2_QUEUE_REQ = 4'h0, P3_QUEUE_REQ = 4'h0, P2_GRANT, P3_GRANT;
  logic P2_TX_SLOT = 1'b0, P3_TX_SLOT = 1'b0, P2_GRANT_VALID, P3_GRANT_VALID;
  int err_count = 0;
  int n_checks = 0;
  localparam logic [11:0] CTRL_ADDR = {`EQW_IDX_CTRL, 2'b00};
  localparam logic [11:0] STAT_ADDR = {`EQW_IDX_STAT, 2'b00};

  egress_queue_split_cfg u_egress_queue_split_cfg (
    .CLK(CLK), .RST(RST),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .P2_QUEUE_REQ(P2_QUEUE_REQ), .P2_TX_SLOT(P2_TX_SLOT), .P2_GRANT(P2_GRANT), .P2_GRANT_VALID(P2_GRANT_VALID),
    .P3_QUEUE_REQ(P3_QUEUE_REQ), .P3_TX_SLOT(P3_TX_SLOT), .P3_GRANT(P3_GRANT), .P3_GRANT_VALID(P3_GRANT_VALID)
  );

  always #5 CLK = ~CLK;

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Handshakes are judged at the falling edge: nothing changes between it and the next rising edge
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    int t;
    b_ok = 1'b0;
    t = 0;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= 4'hF;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!b_ok && t < 100) begin
      @(negedge CLK);
      aw_ok = S_AXI_AWVALID && S_AXI_AWREADY;
      w_ok = S_AXI_WVALID && S_AXI_WREADY;
      b_ok = (S_AXI_BVALID === 1'b1);
      if (b_ok) check(S_AXI_BRESP, er);
      @(posedge CLK);
      if (aw_ok) S_AXI_AWVALID <= 1'b0;
      if (w_ok) S_AXI_WVALID <= 1'b0;
      if (b_ok) S_AXI_BREADY <= 1'b0;
      t++;
    end
    if (!b_ok) check(32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_ok, r_ok;
    int t;
    r_ok = 1'b0;
    t = 0;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    while (!r_ok && t < 100) begin
      @(negedge CLK);
      ar_ok = S_AXI_ARVALID && S_AXI_ARREADY;
      r_ok = (S_AXI_RVALID === 1'b1);
      if (r_ok) check({S_AXI_RRESP, S_AXI_RDATA[29:0]}, {er, ed[29:0]});
      if (r_ok) check(S_AXI_RDATA, ed);
      @(posedge CLK);
      if (ar_ok) S_AXI_ARVALID <= 1'b0;
      if (r_ok) S_AXI_RREADY <= 1'b0;
      t++;
    end
    if (!r_ok) check(32'h0000_0000, 32'h0000_0001);
  endtask

  // Slots every cycle; exp holds the expected grants, first one in the lowest nibble
  task automatic slots(input bit p3, input logic [3:0] req, input int n, input logic [63:0] exp);
    @(posedge CLK);
    if (p3) begin
      P3_QUEUE_REQ <= req;
      P3_TX_SLOT <= 1'b1;
    end else begin
      P2_QUEUE_REQ <= req;
      P2_TX_SLOT <= 1'b1;
    end
    for (int i = 0; i <= n; i++) begin
      @(posedge CLK);
      if (i == n - 1) begin
        P2_TX_SLOT <= 1'b0;
        P3_TX_SLOT <= 1'b0;
      end
      if (i == n) begin
        P2_QUEUE_REQ <= 4'h0;
        P3_QUEUE_REQ <= 4'h0;
      end
      #1;
      check(p3 ? P3_GRANT_VALID : P2_GRANT_VALID, 32'(i < n));
      if (i < n) check(p3 ? P3_GRANT : P2_GRANT, 32'(exp[4*i +: 4]));
    end
  endtask

  function automatic logic [11:0] split_addr(input int i);
    return {10'(`EQW_IDX_P2Q3 + i), 2'b00};
  endfunction

  initial begin
    repeat (20000) @(posedge CLK);
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    for (int i = 0; i < 8; i++) axi_read(split_addr(i), 32'h0000_0080 | (32'h8 >> (i % 4)), `EQW_RESP_OKAY);
    axi_read(12'h000, 32'h0000_0000, `EQW_RESP_SLVERR);
    axi_write(split_addr(0) + 12'h001, 32'h0000_0000, `EQW_RESP_SLVERR);
    axi_read(split_addr(0) + 12'h002, 32'h0000_0000, `EQW_RESP_SLVERR);
    // Reset state is weighted four-queue: one full round of credits
    slots(1'b0, 4'hF, 15, 64'h0122_4444_8888_8888);
    for (int i = 0; i < 4; i++) axi_write(split_addr(i), 32'h0000_0000, `EQW_RESP_OKAY);
    for (int i = 0; i < 4; i++) axi_read(split_addr(i), 32'h8 >> i, `EQW_RESP_OKAY);
    slots(1'b0, 4'hF, 2, 64'h0000_0000_0000_0088);
    slots(1'b0, 4'h3, 3, 64'h0000_0000_0000_0222);
    // Global bit set with all mode bits clear turns weighting back on
    axi_write(CTRL_ADDR, 32'h0000_0001, `EQW_RESP_OKAY);
    slots(1'b0, 4'h3, 3, 64'h0000_0000_0000_0122);
    axi_write(CTRL_ADDR, 32'h0000_0000, `EQW_RESP_OKAY);
    // Port 3 queue three alone cleared: disagreeing bits, reserved field untouched
    axi_write(split_addr(4), 32'hFFFF_FF7F, `EQW_RESP_OKAY);
    axi_read(split_addr(4), 32'h0000_0008, `EQW_RESP_OKAY);
    slots(1'b1, 4'h3, 3, 64'h0000_0000_0000_0222);
    axi_write(split_addr(4), 32'h0000_0080, `EQW_RESP_OKAY);
    axi_write(CTRL_ADDR, 32'h0000_0004, `EQW_RESP_OKAY);
    axi_read(CTRL_ADDR, 32'h0000_0004, `EQW_RESP_OKAY);
    slots(1'b1, 4'hF, 3, 64'h0000_0000_0000_0122);
    // Status is read-only: port 2 strict, port 3 two-queue, both last granted the lowest queue
    axi_write(STAT_ADDR, 32'h0000_0FFF, `EQW_RESP_OKAY);
    axi_read(STAT_ADDR, 32'h0000_0118, `EQW_RESP_OKAY);
    end_of_test();
  end
endmodule // testbench
